// >>> src/ipgc_core.sv
`timescale 1ns/1ps

module ipgc_core
	import ipgc_pkg::*;
(
	input  wire logic                      clock_i,
	input  wire logic                      rstn_i,
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [ADR_W-1:0]          wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	input  wire logic [NUM_INIT-1:0]       acc_valid_i,
	input  wire logic [NUM_INIT-1:0]       acc_write_i,
	input  wire ipgc_mask_t [NUM_INIT-1:0] region_read_mask_i,
	input  wire ipgc_mask_t [NUM_INIT-1:0] region_write_mask_i,
	output ipgc_grp_t  [NUM_INIT-1:0]      groups_o,
	output logic      [NUM_INIT-1:0]       grant_o,
	output logic      [NUM_INIT-1:0]       deny_o
);

	logic [31:0]         initiator_group_config;
	logic [NUM_INIT-1:0] viol_sts;
	ipgc_viol_t          last_viol;
	ipgc_grp_t           grp [NUM_INIT];
	logic                req;
	logic                wr_cfg;
	logic                wr_viol;
	logic [31:0]         lane_mask;
	logic [31:0]         next_cfg;
	logic [31:0]         next_rdata;
	logic [NUM_INIT-1:0] next_grant;
	logic [NUM_INIT-1:0] next_deny;
	logic [NUM_INIT-1:0] next_viol;
	ipgc_viol_t          next_last;

	// ---------------- wishbone slave ----------------
	assign req = wb_cyc_i & wb_stb_i;
	// writes land on the edge where the master samples ack, never earlier
	assign wr_cfg  = req & wb_ack_o & wb_we_i & (wb_adr_i == CFG_OFS);
	assign wr_viol = req & wb_ack_o & wb_we_i & (wb_adr_i == VIOL_OFS);

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			lane_mask[b*8 +: 8] = {8{wb_sel_i[b]}};
		end
	end

	// unimplemented bits are masked on the way in, so they can never read back as one
	always_comb begin
		next_cfg = (initiator_group_config & ~lane_mask) | (wb_dat_i & lane_mask);
		next_cfg = next_cfg & CFG_IMPL_MASK;
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (wb_adr_i)
			CFG_OFS: begin
				next_rdata = initiator_group_config & CFG_IMPL_MASK;
			end
			VIOL_OFS: begin
				next_rdata[NUM_INIT-1:0] = viol_sts;
			end
			LAST_OFS: begin
				next_rdata[$bits(ipgc_viol_t)-1:0] = last_viol;
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	// one wait state: ack rises the cycle after the request and drops after one cycle
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req & ~wb_ack_o & ~wb_we_i) begin
			wb_dat_o <= next_rdata;
		end else begin
			wb_dat_o <= 32'h0000_0000;
		end
	end

	// ---------------- group configuration ----------------
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			initiator_group_config <= CFG_RESET;
		end else if (wr_cfg) begin
			initiator_group_config <= next_cfg;
		end
	end

	assign grp[INIT_ADC]   = initiator_group_config[ADC_LSB +: 2];
	assign grp[INIT_FLASH] = initiator_group_config[FLASH_LSB +: 2];
	assign grp[INIT_CAN4]  = initiator_group_config[CAN4_LSB +: 2];
	assign grp[INIT_CAN3]  = initiator_group_config[CAN3_LSB +: 2];
	assign grp[INIT_CAN2]  = initiator_group_config[CAN2_LSB +: 2];
	assign grp[INIT_CAN1]  = initiator_group_config[CAN1_LSB +: 2];
	assign grp[INIT_USB2]  = initiator_group_config[USB2_LSB +: 2];
	assign grp[INIT_USB1]  = initiator_group_config[USB1_LSB +: 2];
	assign grp[INIT_DMA]   = initiator_group_config[DMA_LSB +: 2];
	assign grp[INIT_CORE]  = initiator_group_config[CORE_LSB +: 2];

	// ---------------- per-initiator permission check ----------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_INIT; gi++) begin : g_init
			logic allowed;

			// plain wiring from the register flops, so the group is valid in the access cycle
			assign groups_o[gi] = grp[gi];

			// the group value indexes one bit of the mask that matches the direction
			assign allowed = acc_write_i[gi] ? region_write_mask_i[gi][grp[gi]]
			                                 : region_read_mask_i[gi][grp[gi]];
			assign next_grant[gi] = acc_valid_i[gi] & allowed;
			assign next_deny[gi]  = acc_valid_i[gi] & ~allowed;

			// a refusal in the same cycle as the software clear keeps the bit set
			assign next_viol[gi] = next_deny[gi] | (viol_sts[gi] & ~(wr_viol & wb_dat_i[gi]));

			AST_GRANT_FOLLOWS_MASK: assert property (@(posedge clock_i) disable iff (!rstn_i)
				acc_valid_i[gi] |=> grant_o[gi] == ($past(acc_write_i[gi])
					? $past(region_write_mask_i[gi][grp[gi]]) : $past(region_read_mask_i[gi][grp[gi]])))
				else $error("grant does not follow the mask bit chosen by the group");

			AST_NO_DECISION_IDLE: assert property (@(posedge clock_i) disable iff (!rstn_i)
				!acc_valid_i[gi] |=> !grant_o[gi] && !deny_o[gi])
				else $error("decision given without an access");

			AST_DENY_STICKY: assert property (@(posedge clock_i) disable iff (!rstn_i)
				deny_o[gi] |-> viol_sts[gi])
				else $error("refused access did not set its status bit");

			AST_DENY_FOLLOWS_MASK: assert property (@(posedge clock_i) disable iff (!rstn_i)
				acc_valid_i[gi] |=> deny_o[gi] == !($past(acc_write_i[gi])
					? $past(region_write_mask_i[gi][grp[gi]]) : $past(region_read_mask_i[gi][grp[gi]])))
				else $error("deny does not follow the mask bit chosen by the group");
		end
	endgenerate

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			grant_o <= '0;
			deny_o  <= '0;
		end else begin
			grant_o <= next_grant;
			deny_o  <= next_deny;
		end
	end

	// ---------------- refusal record ----------------
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			viol_sts <= VIOL_RESET;
		end else begin
			viol_sts <= next_viol;
		end
	end

	// lowest initiator index wins when several are refused together
	always_comb begin
		next_last = last_viol;
		for (int i = NUM_INIT - 1; i >= 0; i--) begin
			if (next_deny[i]) begin
				next_last.valid = 1'b1;
				next_last.write = acc_write_i[i];
				next_last.init  = 4'(i);
				next_last.group = grp[i];
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			last_viol <= LAST_RESET;
		end else begin
			last_viol <= next_last;
		end
	end

	// ---------------- checks ----------------
	AST_ACK_ONE_CYCLE: assert property (@(posedge clock_i) disable iff (!rstn_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	AST_ACK_AFTER_REQ: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(req && !wb_ack_o) |=> wb_ack_o)
		else $error("request not acknowledged on the next cycle");

	AST_RESET_CLEARS: assert property (@(posedge clock_i)
		!rstn_i |=> (initiator_group_config == CFG_RESET) && (groups_o == '0))
		else $error("group fields not zero after reset");

	AST_RSVD_READ_ZERO: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wb_ack_o && $past(wb_adr_i) == CFG_OFS) |-> (wb_dat_o[31:26] == 6'h00) && (wb_dat_o[21:20] == 2'h0))
		else $error("upper unimplemented bits read as one");

	AST_LOW_RSVD_ZERO: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wb_ack_o && $past(wb_adr_i) == CFG_OFS) |-> (wb_dat_o[7:6] == 2'h0) && (wb_dat_o[3:2] == 2'h0))
		else $error("lower unimplemented bits read as one");

	AST_ADC_FIELD: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_cfg && wb_sel_i[3]) |=> groups_o[INIT_ADC] == $past(wb_dat_i[25:24]))
		else $error("converter group not taken from bits 25-24");

	AST_FLASH_FIELD: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_cfg && wb_sel_i[2]) |=> groups_o[INIT_FLASH] == $past(wb_dat_i[23:22]))
		else $error("flash group not taken from bits 23-22");

	AST_CAN_FIELDS: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_cfg && wb_sel_i[2]) |=> {groups_o[INIT_CAN4], groups_o[INIT_CAN3]} == $past(wb_dat_i[19:16]))
		else $error("upper CAN groups not taken from bits 19-16");

	AST_LOW_FIELDS: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_cfg && wb_sel_i[0] && wb_sel_i[1]) |=> ({groups_o[INIT_USB1], groups_o[INIT_DMA], groups_o[INIT_CORE]}
			== {$past(wb_dat_i[9:8]), $past(wb_dat_i[5:4]), $past(wb_dat_i[1:0])}))
		else $error("USB1, DMA or core group not taken from its bits");

	AST_NO_WRITE_NO_CHANGE: assert property (@(posedge clock_i) disable iff (!rstn_i)
		!wr_cfg |=> $stable(groups_o))
		else $error("exported groups changed without a configuration write");

	// each lane write must move exactly the field that sits in it
	AST_CAN3_FIELD: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_cfg && wb_sel_i[2]) |=> groups_o[INIT_CAN3] == $past(wb_dat_i[17:16]))
		else $error("third CAN group not taken from bits 17-16");

	AST_CAN2_FIELD: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_cfg && wb_sel_i[1]) |=> groups_o[INIT_CAN2] == $past(wb_dat_i[15:14]))
		else $error("second CAN group not taken from bits 15-14");

	AST_CAN1_FIELD: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_cfg && wb_sel_i[1]) |=> groups_o[INIT_CAN1] == $past(wb_dat_i[13:12]))
		else $error("first CAN group not taken from bits 13-12");

	AST_USB2_FIELD: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_cfg && wb_sel_i[1]) |=> groups_o[INIT_USB2] == $past(wb_dat_i[11:10]))
		else $error("second USB group not taken from bits 11-10");

	AST_DMA_FIELD: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_cfg && wb_sel_i[0]) |=> groups_o[INIT_DMA] == $past(wb_dat_i[5:4]))
		else $error("DMA group not taken from bits 5-4");

	AST_CORE_FIELD: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_cfg && wb_sel_i[0]) |=> groups_o[INIT_CORE] == $past(wb_dat_i[1:0]))
		else $error("core group not taken from bits 1-0");

	// a disabled lane must leave its fields alone
	AST_LANE_KEEPS_ADC: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_cfg && !wb_sel_i[3]) |=> $stable(groups_o[INIT_ADC]))
		else $error("converter group changed by a write with its lane disabled");

	AST_LANE_KEEPS_CAN2: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_cfg && !wb_sel_i[1]) |=> $stable(groups_o[INIT_CAN2]))
		else $error("second CAN group changed by a write with its lane disabled");

	AST_LANE_KEEPS_CORE: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_cfg && !wb_sel_i[0]) |=> $stable(groups_o[INIT_CORE]))
		else $error("core group changed by a write with its lane disabled");

	// reserved flops must never hold a one, whatever software writes
	AST_UPPER_RSVD_HELD: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(initiator_group_config[31:26] == 6'h00) && (initiator_group_config[21:20] == 2'h0))
		else $error("upper unimplemented bits captured a write");

	AST_LOWER_RSVD_HELD: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(initiator_group_config[7:6] == 2'h0) && (initiator_group_config[3:2] == 2'h0))
		else $error("lower unimplemented bits captured a write");

	AST_UNMAPPED_NO_WRITE: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(req && wb_ack_o && wb_we_i && (wb_adr_i != CFG_OFS)) |=> $stable(initiator_group_config))
		else $error("write to another offset changed the configuration");

	AST_READ_RETURNS_CFG: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wb_ack_o && !$past(wb_we_i) && ($past(wb_adr_i) == CFG_OFS))
			|-> wb_dat_o == $past(initiator_group_config))
		else $error("configuration read does not return the stored fields");

	AST_IDLE_DATA_ZERO: assert property (@(posedge clock_i) disable iff (!rstn_i)
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data driven outside an acknowledge");

	// every access gets exactly one answer, never both
	AST_ONE_DECISION: assert property (@(posedge clock_i) disable iff (!rstn_i)
		1'b1 |=> (grant_o | deny_o) == $past(acc_valid_i))
		else $error("an access did not get exactly one decision");

	AST_GRANT_DENY_EXCL: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(grant_o & deny_o) == '0)
		else $error("grant and deny raised together");

	// status bits only drop through a clear write, and a refusal beats that clear
	AST_STATUS_HOLDS: assert property (@(posedge clock_i) disable iff (!rstn_i)
		!wr_viol |=> (viol_sts & $past(viol_sts)) == $past(viol_sts))
		else $error("status bit dropped without a clear write");

	AST_CLEAR_WORKS: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(wr_viol && !(|next_deny)) |=> (viol_sts & $past(wb_dat_i[NUM_INIT-1:0])) == '0)
		else $error("status bit survived a clear write");

	AST_SET_BEATS_CLEAR: assert property (@(posedge clock_i) disable iff (!rstn_i)
		1'b1 |=> (viol_sts & $past(next_deny)) == $past(next_deny))
		else $error("a refusal was lost to a clear in the same cycle");

	// the record names the lowest refused initiator of the cycle
	AST_LAST_RECORD: assert property (@(posedge clock_i) disable iff (!rstn_i)
		(|next_deny) |=> last_viol.valid && deny_o[last_viol.init]
			&& ((deny_o & ((10'h001 << last_viol.init) - 10'h001)) == '0))
		else $error("last refusal record does not name the lowest refused initiator");

	AST_RESET_OUTPUTS: assert property (@(posedge clock_i)
		!rstn_i |=> !wb_ack_o && (grant_o == '0) && (deny_o == '0) && (viol_sts == '0))
		else $error("outputs or status not cleared by reset");

	COV_CFG_WRITE: cover property (@(posedge clock_i) disable iff (!rstn_i)
		wr_cfg && wb_sel_i == 4'hF);
	COV_DENY_WRITE: cover property (@(posedge clock_i) disable iff (!rstn_i)
		|next_deny && |acc_write_i);
	COV_GRANT_HIGH_GROUP: cover property (@(posedge clock_i) disable iff (!rstn_i)
		grant_o[INIT_ADC] && groups_o[INIT_ADC] == 2'h3);
	COV_CLEAR_COLLIDE: cover property (@(posedge clock_i) disable iff (!rstn_i)
		wr_viol && |(wb_dat_i[NUM_INIT-1:0] & next_deny));
	COV_LANE_WRITE: cover property (@(posedge clock_i) disable iff (!rstn_i)
		wr_cfg && wb_sel_i == 4'h2);

endmodule : ipgc_core

// >>> inc/ipgc_pkg.sv
package ipgc_pkg;
	localparam int NUM_INIT = 10;

	// initiator index order on every per-initiator port
	localparam int INIT_CORE  = 0;
	localparam int INIT_DMA   = 1;
	localparam int INIT_USB1  = 2;
	localparam int INIT_USB2  = 3;
	localparam int INIT_CAN1  = 4;
	localparam int INIT_CAN2  = 5;
	localparam int INIT_CAN3  = 6;
	localparam int INIT_CAN4  = 7;
	localparam int INIT_FLASH = 8;
	localparam int INIT_ADC   = 9;

	// low bit of each 2-bit group field in the configuration word
	localparam int CORE_LSB  = 0;
	localparam int DMA_LSB   = 4;
	localparam int USB1_LSB  = 8;
	localparam int USB2_LSB  = 10;
	localparam int CAN1_LSB  = 12;
	localparam int CAN2_LSB  = 14;
	localparam int CAN3_LSB  = 16;
	localparam int CAN4_LSB  = 18;
	localparam int FLASH_LSB = 22;
	localparam int ADC_LSB   = 24;

	localparam logic [31:0] CFG_IMPL_MASK = 32'h03CF_FF33;
	localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
	localparam logic [9:0]  VIOL_RESET    = 10'h000;

	// wishbone register offsets (byte addresses)
	localparam int          ADR_W    = 8;
	localparam logic [7:0]  CFG_OFS  = 8'h00;
	localparam logic [7:0]  VIOL_OFS = 8'h04;
	localparam logic [7:0]  LAST_OFS = 8'h08;

	typedef logic [1:0] ipgc_grp_t;
	typedef logic [3:0] ipgc_mask_t;

	// last refused access, as read back at LAST_OFS
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [3:0] init;
		ipgc_grp_t  group;
	} ipgc_viol_t;

	localparam ipgc_viol_t LAST_RESET = '{valid: 1'b0, write: 1'b0, init: 4'h0, group: 2'h0};
endpackage : ipgc_pkg

// >>> verification/ipgc_init_model.sv
`timescale 1ns/1ps
module ipgc_init_model
	import ipgc_pkg::*;
(
	input  wire logic                  clock_i,
	output logic       [NUM_INIT-1:0]  acc_valid_o,
	output logic       [NUM_INIT-1:0]  acc_write_o,
	output ipgc_mask_t [NUM_INIT-1:0]  rd_mask_o,
	output ipgc_mask_t [NUM_INIT-1:0]  wr_mask_o
);
	initial begin
		acc_valid_o = '0;
		acc_write_o = '0;
		rd_mask_o = '0;
		wr_mask_o = '0;
	end
	// all initiators hit one region in the same cycle, so every group decode is exercised at once
	task automatic access(input logic wr, input ipgc_mask_t rm, input ipgc_mask_t wm);
		@(posedge clock_i);
		acc_valid_o <= '1;
		acc_write_o <= {NUM_INIT{wr}};
		rd_mask_o <= {NUM_INIT{rm}};
		wr_mask_o <= {NUM_INIT{wm}};
		@(posedge clock_i);
		acc_valid_o <= '0;
		// idle qualifiers are scrambled so a checker that ignores valid shows up
		acc_write_o <= ~acc_write_o;
		rd_mask_o <= ~rd_mask_o;
		wr_mask_o <= ~wr_mask_o;
	endtask : access
endmodule : ipgc_init_model

// >>> verification/ipgc_core_test.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
	$display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module ipgc_core_test
	import ipgc_pkg::*;
;
	logic                      clock_i;
	logic                      rstn_i;
	logic                      wb_cyc_i;
	logic                      wb_stb_i;
	logic                      wb_we_i;
	logic [ADR_W-1:0]          wb_adr_i;
	logic [3:0]                wb_sel_i;
	logic [31:0]               wb_dat_i;
	logic [31:0]               wb_dat_o;
	logic                      wb_ack_o;
	logic [NUM_INIT-1:0]       acc_valid;
	logic [NUM_INIT-1:0]       acc_write;
	ipgc_mask_t [NUM_INIT-1:0] rd_mask;
	ipgc_mask_t [NUM_INIT-1:0] wr_mask;
	ipgc_grp_t [NUM_INIT-1:0]  groups_o;
	logic [NUM_INIT-1:0]       grant_o;
	logic [NUM_INIT-1:0]       deny_o;
	int                        num_errors;
	int                        num_checks;
	int                        cycles;
	localparam int LSB [NUM_INIT] = '{CORE_LSB, DMA_LSB, USB1_LSB, USB2_LSB, CAN1_LSB,
		CAN2_LSB, CAN3_LSB, CAN4_LSB, FLASH_LSB, ADC_LSB};

	ipgc_core dut (.clock_i(clock_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .acc_valid_i(acc_valid), .acc_write_i(acc_write),
		.region_read_mask_i(rd_mask), .region_write_mask_i(wr_mask), .groups_o(groups_o),
		.grant_o(grant_o), .deny_o(deny_o));
	ipgc_init_model pm (.clock_i(clock_i), .acc_valid_o(acc_valid), .acc_write_o(acc_write),
		.rd_mask_o(rd_mask), .wr_mask_o(wr_mask));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	initial begin
		{rstn_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0000_0000;
		num_errors = 0;
		num_checks = 0;
		cycles = 0;
		repeat (8) @(posedge clock_i);
		rstn_i <= 1'b1;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		input logic [3:0] sel, output logic [31:0] rd);
		@(posedge clock_i);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= wd;
		do @(posedge clock_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
		wb_dat_i <= ~wd;
	endtask : wb_xfer

	task automatic wb_write(input logic [7:0] adr, input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] unused;
		wb_xfer(1'b1, adr, wd, sel, unused);
	endtask : wb_write

	task automatic wb_read(input logic [7:0] adr, output logic [31:0] rd);
		wb_xfer(1'b0, adr, 32'h0000_0000, 4'hF, rd);
	endtask : wb_read

	initial begin : main
		logic [31:0]         d;
		logic [31:0]         cfg;
		logic [NUM_INIT-1:0] exp_grant;
		ipgc_mask_t          sel_bit;
		@(posedge rstn_i);
		wb_read(CFG_OFS, d);
		`CHK("cfg reset", 32'h0000_0000, d)
		`CHK("groups reset", {2*NUM_INIT{1'b0}}, groups_o)
		wb_write(CFG_OFS, 32'hFFFF_FFFF, 4'hF);
		wb_read(CFG_OFS, d);
		`CHK("cfg all ones", 32'h03CF_FF33, d)
		// only lane 1 written: bits 15-8 clear, the rest keep their value
		wb_write(CFG_OFS, 32'h0000_0000, 4'h2);
		wb_read(CFG_OFS, d);
		`CHK("cfg lane1", 32'h03CF_0033, d)
		for (int i = 0; i < NUM_INIT; i++) begin
			for (int g = 1; g < 4; g++) begin
				wb_write(CFG_OFS, 32'(g) << LSB[i], 4'hF);
				wb_read(CFG_OFS, d);
				`CHK("cfg field", 32'(g) << LSB[i], d)
				`CHK("group out", ipgc_grp_t'(g), groups_o[i])
			end
		end
		wb_write(8'h0C, 32'hFFFF_FFFF, 4'hF);
		wb_read(8'h0C, d);
		`CHK("unmapped", 32'h0000_0000, d)
		// the last field write left only the converter group at 3
		wb_read(CFG_OFS, d);
		`CHK("cfg after unmapped", 32'h0300_0000, d)
		cfg = 32'h0000_0000;
		for (int i = 0; i < NUM_INIT; i++) cfg |= 32'(i % 4) << LSB[i];
		wb_write(CFG_OFS, cfg, 4'hF);
		// the mask of the other direction is all ones, so using the wrong mask grants everyone
		for (int w = 0; w < 2; w++) begin
			for (int n = 0; n < 4; n++) begin
				sel_bit = ipgc_mask_t'(1 << n);
				for (int i = 0; i < NUM_INIT; i++) exp_grant[i] = (i % 4) == n;
				pm.access(w[0], w ? 4'hF : sel_bit, w ? sel_bit : 4'hF);
				@(posedge clock_i);
				`CHK("grant", exp_grant, grant_o)
				`CHK("deny", ~exp_grant, deny_o)
			end
		end
		// every initiator was refused above; the final write refused core as the lowest refused initiator, in group 0
		wb_read(VIOL_OFS, d);
		`CHK("status", 32'h0000_03FF, d)
		wb_read(LAST_OFS, d);
		`CHK("last refusal", 32'h0000_00C0, d)
		wb_write(VIOL_OFS, 32'h0000_03FF, 4'hF);
		wb_read(VIOL_OFS, d);
		`CHK("status clear", 32'h0000_0000, d)
		wrap_up();
	end
endmodule : ipgc_core_test
